// >>> logic/ssd_params.svh
`ifndef SSD_PARAMS_SVH
`define SSD_PARAMS_SVH

// register byte offsets
`define SSD_ADDR_CTRL       4'h0
`define SSD_ADDR_STATUS     4'h4
`define SSD_ADDR_SHADOW     4'h8
`define SSD_ADDR_PIPE       4'hC

// control register fields
`define SSD_CTRL_DIAG_EN    0
`define SSD_CTRL_RESET      1'b0

// status register fields
`define SSD_STAT_MODE       0
`define SSD_STAT_SOUT       1
`define SSD_STAT_SIN        2
`define SSD_STAT_WORD_RDY   3
`define SSD_STAT_DIAG_EN    4

// microword layout
`define SSD_WORD_W          32
`define SSD_UPPER_LO        8
`define SSD_UPPER_W         8
`define SSD_SRC_BIT         31
`define SSD_DIAG_CLK_BIT    7
`define SSD_MODE_BIT        6

// synchronised pin vector positions
`define SSD_SYN_DIAG_CLK    0
`define SSD_SYN_MODE        1
`define SSD_SYN_SIN         2
`define SSD_SYN_UPPER_LO    3
`define SSD_SYN_W           11

`define SSD_FIFO_DEPTH      4

`endif

// >>> logic/ssd_pkg.sv
package ssd_pkg;

   typedef enum logic [2:0]
   {
      SSD_OP_IDLE    = 3'b000,
      SSD_OP_SHIFT   = 3'b001,
      SSD_OP_CAPTURE = 3'b010,
      SSD_OP_HOLD    = 3'b011,
      SSD_OP_LD_SHAD = 3'b100,
      SSD_OP_LD_MEM  = 3'b101
   } ssd_op_e;

   typedef struct packed
   {
      logic [31:0] shadow;
      logic [31:0] pipe;
      logic        diag_en;
      logic        diag_clk_prev;
      logic        sout;
      logic        zero_out;
      logic        cond_out;
      logic        ack;
      logic [31:0] rdata;
      ssd_op_e     last_op;
   } ssd_state_s;

endpackage

// >>> logic/ssd_sync.sv
`timescale 1ns/1ps
module ssd_sync
#(
   parameter int WIDTH = 1
)
(
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // asynchronous in, synchronised out
   input  wire logic [WIDTH-1:0] async_i,
   output      logic [WIDTH-1:0] sync_o
);

   typedef struct packed
   {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } ssd_sync_s;

   ssd_sync_s st_ff;
   ssd_sync_s nxt_st;

   // first stage feeds only the second stage
   always_comb
   begin
      nxt_st    = st_ff;
      nxt_st.s1 = async_i;
      nxt_st.s2 = st_ff.s1;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign sync_o = st_ff.s2;

endmodule

// >>> logic/ssd_fifo.sv
`timescale 1ns/1ps
module ssd_fifo
#(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
)
(
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // fill side
   input  wire logic             in_valid_i,
   output      logic             in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // drain side
   output      logic             out_valid_o,
   input  wire logic             out_ready_i,
   output      logic [WIDTH-1:0] out_data_o
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed
   {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr_ptr;
      logic [AW-1:0]               rd_ptr;
      logic [AW:0]                 count;
   } ssd_fifo_s;

   ssd_fifo_s st_ff;
   ssd_fifo_s nxt_st;
   logic      push;
   logic      pop;

   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      if (p == AW'(DEPTH - 1))
      begin
         ptr_inc = '0;
      end
      else
      begin
         ptr_inc = p + AW'(1);
      end
   endfunction

   assign in_ready_o  = (st_ff.count != (AW+1)'(DEPTH));
   assign out_valid_o = (st_ff.count != '0);
   assign out_data_o  = st_ff.mem[st_ff.rd_ptr];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   always_comb
   begin
      nxt_st = st_ff;
      if (push)
      begin
         nxt_st.mem[st_ff.wr_ptr] = in_data_i;
         nxt_st.wr_ptr            = ptr_inc(st_ff.wr_ptr);
      end
      if (pop)
      begin
         nxt_st.rd_ptr = ptr_inc(st_ff.rd_ptr);
      end
      if (push && !pop)
      begin
         nxt_st.count = st_ff.count + (AW+1)'(1);
      end
      else if (pop && !push)
      begin
         nxt_st.count = st_ff.count - (AW+1)'(1);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

endmodule

// >>> logic/ssd_shadow_diag.sv
// Function
// [RL1] diagnostics build holds a 32-bit shadow register on pipeline inputs
// [RL2] condition pin is serial in, zero pin serial out, P7 clock, P6 mode
// [RL3] mode low, diag clock rise: shift right, bit 31 from serial in
// [RL4] serial in low, mode high, diag rise: shadow takes pipeline, out low
// [RL5] serial in high, mode high, diag rise: both hold, out high
// [RL6] mode low, system step: pipeline loads program word, shadow holds
// [RL7] condition pin still reaches the sequencer as branch condition
// [RL8] mode high, system step: pipeline takes shadow, out follows serial in
// [RL9] capture takes shadow bits 15..8 from the upper byte pins
// [RL10] capture leaves shadow bits 7 and 6 without meaning
// [RL11] controller shifts a microword in, then moves it into pipeline
// [RL12] result is stepped into pipeline, captured, then shifted out
// [RL13] diagnostics exist only when the configuration option is on
// [RL14] controller never raises diag clock with a system step
// [RL15] normal configuration: zero pin shows counter, condition pin passes
//
// The Wishbone interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "ssd_params.svh"
module ssd_shadow_diag
   import ssd_pkg::*;
#(
   parameter int WORD_W     = `SSD_WORD_W,
   parameter int FIFO_DEPTH = `SSD_FIFO_DEPTH
)
(
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // wishbone slave
   input  wire logic              cyc_i,
   input  wire logic              stb_i,
   input  wire logic              we_i,
   input  wire logic [3:0]        adr_i,
   input  wire logic [3:0]        sel_i,
   input  wire logic [31:0]       dat_i,
   output      logic [31:0]       dat_o,
   output      logic              ack_o,
   // program memory word stream
   input  wire logic              prog_valid_i,
   output      logic              prog_ready_o,
   input  wire logic [WORD_W-1:0] prog_word_i,
   // sequencer side, same clock
   input  wire logic              sys_step_i,
   input  wire logic              counter_zero_i,
   output      logic              cond_o,
   output      logic [WORD_W-1:0] pipe_o,
   // pins to and from the diagnostic controller
   input  wire logic              condition_input_i,
   input  wire logic              diag_clock_i,
   input  wire logic              diag_mode_i,
   output      logic              counter_zero_out_o,
   output      logic              diag_pins_oe_o,
   // upper output byte, two-way
   input  wire logic [7:0]        upper_byte_i,
   output      logic [7:0]        upper_byte_o,
   output      logic              upper_byte_oe_o
);

   ssd_state_s              st_ff;
   ssd_state_s              nxt_st;
   ssd_op_e                 op;
   logic [`SSD_SYN_W-1:0]   syn_raw;
   logic [`SSD_SYN_W-1:0]   syn;
   logic                    diag_clk_s;
   logic                    mode_s;
   logic                    sin_s;
   logic [7:0]              upper_s;
   logic                    diag_clk_rise;
   logic                    word_valid;
   logic                    word_take;
   logic [WORD_W-1:0]       word_data;
   logic                    wb_req;
   logic [WORD_W-1:0]       capture_val;

   // every pin from the diagnostic controller passes two flip-flops
   assign syn_raw = {upper_byte_i, condition_input_i,
                     diag_mode_i, diag_clock_i};

   ssd_sync
   #(
      .WIDTH (`SSD_SYN_W)
   )
   u_sync
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i (syn_raw),
      .sync_o  (syn)
   );

   assign diag_clk_s = syn[`SSD_SYN_DIAG_CLK];
   assign mode_s  = syn[`SSD_SYN_MODE];
   assign sin_s   = syn[`SSD_SYN_SIN];
   assign upper_s = syn[`SSD_SYN_UPPER_LO +: 8];

   // program words wait here; a diag load takes none, and the source stalls once FIFO_DEPTH words wait
   ssd_fifo
   #(
      .WIDTH (WORD_W),
      .DEPTH (FIFO_DEPTH)
   )
   u_fifo
   (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (prog_valid_i),
      .in_ready_o  (prog_ready_o),
      .in_data_i   (prog_word_i),
      .out_valid_o (word_valid),
      .out_ready_i (word_take),
      .out_data_o  (word_data)
   );

   // read mux, also used for status snapshot
   function automatic logic [31:0] reg_read(input logic [3:0] a,
                                            input ssd_state_s s,
                                            input logic m,
                                            input logic si,
                                            input logic wv);
      logic [31:0] r;
      r = '0;
      if (a == `SSD_ADDR_CTRL)
      begin
         r[`SSD_CTRL_DIAG_EN] = s.diag_en;
      end
      else if (a == `SSD_ADDR_STATUS)
      begin
         r[`SSD_STAT_MODE]     = m;
         r[`SSD_STAT_SOUT]     = s.sout;
         r[`SSD_STAT_SIN]      = si;
         r[`SSD_STAT_WORD_RDY] = wv;
         r[`SSD_STAT_DIAG_EN]  = s.diag_en;
      end
      else if (a == `SSD_ADDR_SHADOW)
      begin
         r = s.shadow;
      end
      else if (a == `SSD_ADDR_PIPE)
      begin
         r = s.pipe;
      end
      reg_read = r;
   endfunction

   // one row of the mode table for this cycle
   function automatic ssd_op_e pick_op(input logic step,
                                       input logic rise,
                                       input logic en,
                                       input logic m,
                                       input logic si,
                                       input logic wv);
      ssd_op_e o;
      o = SSD_OP_IDLE;
      // a system step wins over a diag edge in the same cycle
      if (step)
      begin
         if (en && m)
         begin
            o = SSD_OP_LD_SHAD;
         end
         else if (wv)
         begin
            o = SSD_OP_LD_MEM;
         end
      end
      else if (rise) // RL14
      begin
         if (!m)
         begin
            o = SSD_OP_SHIFT;
         end
         else if (!si)
         begin
            o = SSD_OP_CAPTURE;
         end
         else
         begin
            o = SSD_OP_HOLD;
         end
      end
      pick_op = o;
   endfunction

   // only byte lane 0 carries a control field
   function automatic logic ctrl_write(input logic [3:0] a,
                                       input logic       w,
                                       input logic [3:0] s);
      logic hit;
      hit = 1'b0;
      if (w && s[0])
      begin
         if (a == `SSD_ADDR_CTRL)
         begin
            hit = 1'b1;
         end
      end
      ctrl_write = hit;
   endfunction

   assign diag_clk_rise = st_ff.diag_en & diag_clk_s & ~st_ff.diag_clk_prev;
   assign wb_req        = cyc_i & stb_i & ~st_ff.ack;

   // clock and mode bits are pins in this build, so they capture as zero;
   // the upper byte is whatever stands on the pins, ours or from outside
   for (genvar g = 0; g < WORD_W; g++)
   begin : g_cap
      if (g >= `SSD_UPPER_LO && g < `SSD_UPPER_LO + `SSD_UPPER_W)
      begin : g_pin
         assign capture_val[g] = upper_s[g - `SSD_UPPER_LO]; // RL9
      end
      else if (g == `SSD_DIAG_CLK_BIT || g == `SSD_MODE_BIT)
      begin : g_zero
         assign capture_val[g] = 1'b0; // RL10
      end
      else
      begin : g_pipe
         assign capture_val[g] = st_ff.pipe[g];
      end
   end

   // memory word is consumed only on a step that actually loads it
   assign word_take = (op == SSD_OP_LD_MEM); // RL6

   always_comb
   begin
      nxt_st               = st_ff;
      op                   = pick_op(sys_step_i, diag_clk_rise,
                                     st_ff.diag_en, mode_s, sin_s,
                                     word_valid);
      nxt_st.diag_clk_prev = diag_clk_s;
      nxt_st.cond_out      = sin_s; // RL7 RL15
      case (op)
         SSD_OP_LD_SHAD:
         begin
            nxt_st.pipe = st_ff.shadow; // RL8 RL11
         end
         SSD_OP_LD_MEM:
         begin
            nxt_st.pipe = word_data; // RL6 RL12
         end
         SSD_OP_SHIFT:
         begin
            nxt_st.shadow = {sin_s, st_ff.shadow[WORD_W-1:1]}; // RL3
         end
         SSD_OP_CAPTURE:
         begin
            nxt_st.shadow = capture_val; // RL4 RL12
         end
         SSD_OP_HOLD:
         begin
            nxt_st.shadow = st_ff.shadow; // RL5
         end
         default:
         begin
            nxt_st.pipe = st_ff.pipe;
         end
      endcase
      if (op != SSD_OP_IDLE)
      begin
         nxt_st.last_op = op;
      end
      // serial out: bit 0 in mode low, else echoes serial in
      if (mode_s)
      begin
         nxt_st.sout = sin_s; // RL4 RL5 RL8
      end
      else
      begin
         nxt_st.sout = nxt_st.shadow[0]; // RL3 RL6
      end
      if (st_ff.diag_en)
      begin
         nxt_st.zero_out = nxt_st.sout; // RL2
      end
      else
      begin
         nxt_st.zero_out = counter_zero_i; // RL13 RL15
      end
      // wishbone: answer one cycle after the request, drop ack next cycle
      nxt_st.ack = wb_req;
      if (wb_req)
      begin
         nxt_st.rdata = reg_read(adr_i, st_ff, mode_s, sin_s, word_valid);
         if (ctrl_write(adr_i, we_i, sel_i))
         begin
            nxt_st.diag_en = dat_i[`SSD_CTRL_DIAG_EN]; // RL13
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_ff         <= '0;
         st_ff.diag_en <= `SSD_CTRL_RESET;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // outputs
   assign dat_o              = st_ff.rdata;
   assign ack_o              = st_ff.ack;
   assign pipe_o             = st_ff.pipe; // RL1
   assign cond_o             = st_ff.cond_out;
   assign counter_zero_out_o = st_ff.zero_out;
   // P7/P6 turn into inputs while diagnostics are on
   assign diag_pins_oe_o     = ~st_ff.diag_en; // RL2
   assign upper_byte_o       = st_ff.pipe[15:8];
   assign upper_byte_oe_o    = st_ff.pipe[`SSD_SRC_BIT]; // RL9

endmodule

// >>> tb/ssd_shadow_diag_props.sv
`timescale 1ns/1ps
module ssd_shadow_diag_props
#(
   parameter int WORD_W = 32
)
(
   // clock and reset
   input wire logic              clk_i,
   input wire logic              rst_i,
   // bus and sequencer
   input wire logic              cyc_i,
   input wire logic              stb_i,
   input wire logic              ack_o,
   input wire logic              sys_step_i,
   input wire logic              counter_zero_i,
   input wire logic              cond_o,
   input wire logic [WORD_W-1:0] pipe_o,
   // pins
   input wire logic              condition_input_i,
   input wire logic              diag_mode_i,
   input wire logic              counter_zero_out_o,
   input wire logic              diag_pins_oe_o,
   input wire logic [7:0]        upper_byte_o,
   input wire logic              upper_byte_oe_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   AST_ACK_NEXT:
      assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not acked");
   AST_ACK_ONE:
      assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   AST_PIPE_STEP:
      assert property ($changed(pipe_o) |-> $past(sys_step_i))
      else $error("pipeline moved without a step");
   AST_SRC_OE:
      assert property (upper_byte_oe_o == pipe_o[WORD_W-1])
      else $error("upper byte enable not from source bit");
   AST_UPPER_OUT:
      assert property (upper_byte_o == pipe_o[15:8])
      else $error("upper byte not from pipeline");
   AST_ZERO_NORMAL:
      assert property (diag_pins_oe_o && $past(diag_pins_oe_o)
         |-> counter_zero_out_o == $past(counter_zero_i))
      else $error("zero pin not showing counter");
   // sync latency allowed for by the settle window
   AST_COND_SYNC:
      assert property ($stable(condition_input_i) [*6]
         |-> cond_o == condition_input_i)
      else $error("condition not reaching sequencer");
   AST_SOUT_HI:
      assert property ((!diag_pins_oe_o && diag_mode_i
         && $stable(condition_input_i)) [*6]
         |-> counter_zero_out_o == condition_input_i)
      else $error("serial out not following serial in");
   cover property (sys_step_i && !diag_pins_oe_o && diag_mode_i);
   cover property (!diag_pins_oe_o && !diag_mode_i
      && $rose(counter_zero_out_o));
   cover property (ack_o && !upper_byte_oe_o);
endmodule

bind ssd_shadow_diag ssd_shadow_diag_props #(.WORD_W(WORD_W)) i_props
(
   .clk_i,
   .rst_i,
   .cyc_i,
   .stb_i,
   .ack_o,
   .sys_step_i,
   .counter_zero_i,
   .cond_o,
   .pipe_o,
   .condition_input_i,
   .diag_mode_i,
   .counter_zero_out_o,
   .diag_pins_oe_o,
   .upper_byte_o,
   .upper_byte_oe_o
);

// >>> tb/ssd_diag_ctl.sv
`timescale 1ns/1ps
module ssd_diag_ctl
(
   // pacing clock
   input  wire logic       clk_i,
   // device pins
   output      logic       sin_o,
   output      logic       diag_clk_o,
   output      logic       mode_o,
   input  wire logic       sout_i,
   input  wire logic       oe_i,
   input  wire logic [7:0] dev_byte_i,
   output      logic [7:0] pin_byte_o
);
   logic [7:0] ext_ff;
   // device wins the byte while it drives
   assign pin_byte_o = oe_i ? dev_byte_i : ext_ff;
   initial
   begin
      sin_o = 1'h0;
      diag_clk_o = 1'h0;
      mode_o = 1'h0;
      ext_ff = 8'h00;
   end
   // 160 ns period; clock stands low between ticks
   task automatic tick(input logic m, input logic d, output logic so);
      @(posedge clk_i);
      mode_o <= m;
      sin_o <= d;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      so = sout_i;
      @(posedge clk_i);
      diag_clk_o <= 1'h1;
      repeat (3) @(posedge clk_i);
      diag_clk_o <= 1'h0;
   endtask
   // lsb first in, old contents out
   task automatic shift(input logic [31:0] w, output logic [31:0] r);
      for (int i = 0; i < 32; i++)
         tick(1'h0, w[i], r[i]);
      sin_o <= ~sin_o;
   endtask
   task automatic capture(input logic [7:0] e, output logic so);
      @(posedge clk_i);
      ext_ff <= e;
      tick(1'h1, 1'h0, so);
   endtask
endmodule

// >>> tb/ssd_shadow_diag_bench.sv
`timescale 1ns/1ps
module ssd_shadow_diag_bench;
   logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, prog_valid_i, b;
   logic        prog_ready_o, sys_step_i, counter_zero_i, cond_o, sin;
   logic        diag_clk, mode, sout, pins_oe, ub_oe;
   logic [3:0]  adr_i, sel_i, lanes;
   logic [7:0]  ub_i, ub_o;
   logic [31:0] dat_i, dat_o, prog_word_i, pipe_o, r, w, e, s;
   logic [31:0] q [5];
   int          fails, n_checks, seed;

   ssd_shadow_diag i_dut
   (
      .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
      .dat_i, .dat_o, .ack_o, .prog_valid_i, .prog_ready_o, .prog_word_i,
      .sys_step_i, .counter_zero_i, .cond_o, .pipe_o,
      .condition_input_i(sin), .diag_clock_i(diag_clk), .diag_mode_i(mode),
      .counter_zero_out_o(sout), .diag_pins_oe_o(pins_oe),
      .upper_byte_i(ub_i), .upper_byte_o(ub_o), .upper_byte_oe_o(ub_oe)
   );
   ssd_diag_ctl i_ctl
   (
      .clk_i, .sin_o(sin), .diag_clk_o(diag_clk), .mode_o(mode),
      .sout_i(sout),
      .oe_i(ub_oe), .dev_byte_i(ub_o), .pin_byte_o(ub_i)
   );

   initial
   begin
      clk_i = 1'h0;
      forever #10 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
      counter_zero_i <= !rst_i && 1'($random(seed));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic we, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
      @(posedge clk_i);
      cyc_i <= 1'h1;
      stb_i <= 1'h1;
      we_i <= we;
      sel_i <= lanes;
      adr_i <= a;
      dat_i <= d;
      do @(posedge clk_i); while (ack_o !== 1'h1);
      rd = dat_o;
      cyc_i <= 1'h0;
      stb_i <= 1'h0;
   endtask
   task automatic step();
      @(posedge clk_i);
      sys_step_i <= 1'h1;
      @(posedge clk_i);
      sys_step_i <= 1'h0;
      @(negedge clk_i);
   endtask
   // s7 and s6 come back as zero by design choice
   function automatic logic [31:0] cap(input logic [31:0] p,
                                       input logic [7:0] x);
      return {p[31:16], p[31] ? p[15:8] : x, 2'h0, p[5:0]};
   endfunction
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial
   begin
      #200000;
      fails++;
      complete_run();
   end

   initial
   begin
      seed = 73;
      fails = 0;
      n_checks = 0;
      s = 32'h0;
      {rst_i, cyc_i, stb_i, we_i, prog_valid_i, sys_step_i} = 6'h20;
      {adr_i, sel_i, dat_i, prog_word_i} = '0;
      lanes = 4'hF;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'h0;
      // control write without lane 0 must not switch the option on
      lanes = 4'hE;
      wb(1'h1, 4'h0, 32'h1, r);
      lanes = 4'hF;
      wb(1'h1, 4'h2, 32'h1, r);
      wb(1'h0, 4'h0, 32'h0, r);
      chk(r, 32'h0);
      chk({31'h0, pins_oe}, 32'h1);
      $display("registers done");
      for (int i = 0; i < 5; i++)
      begin
         q[i] = $random(seed);
         @(posedge clk_i);
         prog_valid_i <= 1'h1;
         prog_word_i <= q[i];
      end
      @(negedge clk_i);
      chk({31'h0, prog_ready_o}, 32'h0);
      @(posedge clk_i);
      prog_valid_i <= 1'h0;
      for (int i = 0; i < 5; i++)
      begin
         step();
         chk(pipe_o, q[i < 4 ? i : 3]);
      end
      chk({31'h0, prog_ready_o}, 32'h1);
      chk({31'h0, cond_o}, {31'h0, sin});
      $display("normal done");
      wb(1'h1, 4'h0, 32'h1, r);
      @(negedge clk_i);
      chk({31'h0, pins_oe}, 32'h0);
      for (int k = 0; k < 3; k++)
      begin
         w = $random(seed);
         e = $random(seed);
         if (k < 2)
            w[31] = k[0];
         i_ctl.shift(w, r);
         chk(r, s);
         wb(1'h0, 4'h8, 32'h0, r);
         chk(r, w);
         i_ctl.tick(1'h1, 1'h1, b);
         chk({31'h0, b}, 32'h1);
         wb(1'h0, 4'h8, 32'h0, r);
         chk(r, w);
         step();
         chk(pipe_o, w);
         wb(1'h0, 4'hC, 32'h0, r);
         chk(r, w);
         i_ctl.capture(e[7:0], b);
         chk({31'h0, b}, 32'h0);
         s = cap(w, e[7:0]);
         wb(1'h0, 4'h8, 32'h0, r);
         chk(r, s);
      end
      $display("diagnostics done");
      wb(1'h1, 4'h0, 32'h0, r);
      i_ctl.tick(1'h0, 1'h1, b);
      wb(1'h0, 4'h8, 32'h0, r);
      chk(r, s);
      wb(1'h0, 4'h4, 32'h0, r);
      chk(r, {29'h0, sin, s[0], 1'h0});
      chk({31'h0, pins_oe}, 32'h1);
      $display("option off done");
      complete_run();
   end
endmodule
